/* ipsr_regs.sv */
// interrupt controller register set: flags, enables, priorities, cpu level and trap status
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
module ipsr_regs
    import ipsr_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire ipsr_pkg::ipsr_bus_t           bus,
    output logic [ipsr_pkg::IPSR_DW-1:0]       bus_rdata,
    input  wire logic [ipsr_pkg::IPSR_NSRC-1:0] src_req,
    input  wire logic [ipsr_pkg::IPSR_NEXT-1:0] ext_irq,
    input  wire logic [3:0]                    trap_event,
    input  wire logic                          trap_ack,
    input  wire logic                          irq_ack,
    input  wire logic                          level_restore,
    input  wire logic [3:0]                    level_restore_val,
    output ipsr_pkg::ipsr_cpu_req_t            cpu_req,
    output logic [3:0]                         cpu_level,
    output logic                               alt_vector_select,
    output logic                               nesting_disable
);
    import ipsr_pkg::*;

    ipsr_state_t s_r;
    ipsr_state_t s_nxt;

    logic                 win_valid;
    logic [IPSR_VW-1:0]   win_vec;
    logic [2:0]           win_lvl;
    logic [IPSR_NSRC-1:0] pend;

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    assign pend = s_r.flags[IPSR_NSRC-1:0] & s_r.enables[IPSR_NSRC-1:0];

    ipsr_arbiter #(
        .N  (IPSR_NSRC),
        .VW (IPSR_VW)
    ) u_arb (
        .pend      (pend),
        .prio      (s_r.prio),
        .win_valid (win_valid),
        .win_vec   (win_vec),
        .win_lvl   (win_lvl)
    );

    // ------------------------------------------------------------
    // cpu side outputs
    // ------------------------------------------------------------
    // a top bit of 1 puts the cpu above every user level, so traps stay unmasked
    assign cpu_level         = {s_r.lvl_top, s_r.lvl_lo};
    assign cpu_req.req       = win_valid && ({1'b0, win_lvl} > cpu_level);
    assign cpu_req.vector    = win_vec;
    assign cpu_req.level     = win_lvl;
    assign alt_vector_select = s_r.alt_table;
    assign nesting_disable   = s_r.nest_off;
    assign bus_rdata         = s_r.rdata;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [IPSR_NBITS-1:0] set_v;
        logic [IPSR_NEXT-1:0]  edge_v;
        logic [IPSR_DW-1:0]    rd_v;
        int                    idx;
        int                    src;
        set_v  = '0;
        edge_v = '0;
        rd_v   = '0;
        idx    = 0;
        src    = 0;
        s_nxt  = s_r;

        // pin synchroniser; only the second stage and its history are read
        s_nxt.ext_s1   = ext_irq;
        s_nxt.ext_s2   = s_r.ext_s1;
        s_nxt.ext_prev = s_r.ext_s2;

        // external edges by polarity: 1 falling, 0 rising
        for (int e = 0; e < IPSR_NEXT; e++) begin
            edge_v[e] = s_r.ext_pol[e] ? (s_r.ext_prev[e] & ~s_r.ext_s2[e])
                                       : (~s_r.ext_prev[e] & s_r.ext_s2[e]);
        end

        // hardware request sources, placed by vector number
        set_v[IPSR_NSRC-1:0] = src_req;
        for (int e = 0; e < IPSR_NEXT; e++) begin
            if (edge_v[e]) begin
                set_v[IPSR_EXT_VEC[e]] = 1'b1;
            end
        end

        // software writes
        if (bus.wr) begin
            if (bus.addr == IPSR_IDX_CTL1) begin
                s_nxt.nest_off = bus.wdata[IPSR_NEST_OFF_BIT];
                s_nxt.trap   = bus.wdata[IPSR_TRAP_LO +: 4];
            end else if (bus.addr == IPSR_IDX_CTL2) begin
                s_nxt.alt_table = bus.wdata[IPSR_ALT_TABLE_BIT];
                s_nxt.ext_pol = bus.wdata[IPSR_NEXT-1:0];
            end else if (bus.addr >= IPSR_IDX_FLAG0 && bus.addr < IPSR_IDX_EN0) begin
                idx = int'(bus.addr - IPSR_IDX_FLAG0);
                s_nxt.flags[idx*IPSR_DW +: IPSR_DW] = bus.wdata;
            end else if (bus.addr >= IPSR_IDX_EN0 && bus.addr < IPSR_IDX_PRIO0) begin
                idx = int'(bus.addr - IPSR_IDX_EN0);
                s_nxt.enables[idx*IPSR_DW +: IPSR_DW] = bus.wdata;
            // slot 15 has no register, which leaves 16 priority registers in the controller
            end else if (bus.addr >= IPSR_IDX_PRIO0 && bus.addr != IPSR_IDX_PRIO0 + IPSR_PRIO_GAP
                         && bus.addr < IPSR_IDX_PRIO0 + 8'(IPSR_NPRIO_REG)) begin
                idx = int'(bus.addr - IPSR_IDX_PRIO0);
                for (int j = 0; j < 4; j++) begin
                    src = idx * 4 + j;
                    if (src < IPSR_NSRC) begin
                        s_nxt.prio[src] = bus.wdata[j*IPSR_PRIO_STEP +: 3];
                    end
                end
            end else if (bus.addr == IPSR_IDX_CPUST) begin
                if (!s_r.nest_off) begin
                    s_nxt.lvl_lo = bus.wdata[IPSR_LVL_LO +: 3];
                end
            end else if (bus.addr == IPSR_IDX_CORE) begin
                // clear only: a 1 written here is dropped
                if (!bus.wdata[IPSR_LVL_TOP_BIT]) begin
                    s_nxt.lvl_top = 1'b0;
                end
            end
        end

        // hardware sets win over a clear in the same cycle; unbuilt bits stay 0
        s_nxt.flags   = (s_nxt.flags | set_v) & IPSR_IMPL_MASK;
        s_nxt.enables = s_nxt.enables & IPSR_IMPL_MASK;
        s_nxt.trap    = s_nxt.trap | trap_event;

        // cpu level changes from the core outrank a software write
        if (level_restore) begin
            s_nxt.lvl_lo  = level_restore_val[2:0];
            s_nxt.lvl_top = level_restore_val[3];
        end
        if (trap_ack) begin
            s_nxt.lvl_top = 1'b1;
        end
        if (irq_ack && cpu_req.req) begin
            // no nesting: run the handler at level 7 so nothing else gets in
            s_nxt.lvl_lo   = s_r.nest_off ? IPSR_LVL_MAX : win_lvl;
            s_nxt.test_vec = win_vec;
            s_nxt.test_lvl = {1'b0, win_lvl};
        end

        // read path, data stand one cycle after the strobe
        if (bus.addr == IPSR_IDX_CTL1) begin
            rd_v[IPSR_NEST_OFF_BIT]  = s_r.nest_off;
            rd_v[IPSR_TRAP_LO +: 4]  = s_r.trap;
        end else if (bus.addr == IPSR_IDX_CTL2) begin
            rd_v[IPSR_ALT_TABLE_BIT] = s_r.alt_table;
            rd_v[IPSR_NEXT-1:0]      = s_r.ext_pol;
        end else if (bus.addr >= IPSR_IDX_FLAG0 && bus.addr < IPSR_IDX_EN0) begin
            idx  = int'(bus.addr - IPSR_IDX_FLAG0);
            rd_v = s_r.flags[idx*IPSR_DW +: IPSR_DW];
        end else if (bus.addr >= IPSR_IDX_EN0 && bus.addr < IPSR_IDX_PRIO0) begin
            idx  = int'(bus.addr - IPSR_IDX_EN0);
            rd_v = s_r.enables[idx*IPSR_DW +: IPSR_DW];
        end else if (bus.addr >= IPSR_IDX_PRIO0 && bus.addr != IPSR_IDX_PRIO0 + IPSR_PRIO_GAP
                     && bus.addr < IPSR_IDX_PRIO0 + 8'(IPSR_NPRIO_REG)) begin
            idx = int'(bus.addr - IPSR_IDX_PRIO0);
            for (int j = 0; j < 4; j++) begin
                src = idx * 4 + j;
                if (src < IPSR_NSRC) begin
                    rd_v[j*IPSR_PRIO_STEP +: 3] = s_r.prio[src];
                end
            end
        end else if (bus.addr == IPSR_IDX_TEST) begin
            rd_v[IPSR_VW-1:0]        = s_r.test_vec;
            rd_v[IPSR_TEST_LVL +: 4] = s_r.test_lvl;
        end else if (bus.addr == IPSR_IDX_CPUST) begin
            rd_v[IPSR_LVL_LO +: 3]   = s_r.lvl_lo;
        end else if (bus.addr == IPSR_IDX_CORE) begin
            rd_v[IPSR_LVL_TOP_BIT]   = s_r.lvl_top;
        end
        s_nxt.rdata = bus.rd ? rd_v : '0;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r     <= '0;
            s_r.lvl_lo <= IPSR_RST_LVL;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

/* ipsr_pkg.sv */
// constants, field positions and carrier types of the interrupt priority and status register block
package ipsr_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int IPSR_NSRC      = 68;     // user vectors 0..67
    localparam int IPSR_NFLAG_REG = 5;
    localparam int IPSR_NPRIO_REG = 17;     // slots 0..16, slot 15 not built
    localparam int IPSR_NEXT      = 5;
    localparam int IPSR_AW        = 8;
    localparam int IPSR_DW        = 16;
    localparam int IPSR_VW        = 7;
    localparam int IPSR_NBITS     = IPSR_NFLAG_REG * IPSR_DW;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IPSR_IDX_CTL1  = 8'h00;
    localparam logic [7:0] IPSR_IDX_CTL2  = 8'h01;
    localparam logic [7:0] IPSR_IDX_FLAG0 = 8'h02;
    localparam logic [7:0] IPSR_IDX_EN0   = 8'h07;
    localparam logic [7:0] IPSR_IDX_PRIO0 = 8'h0c;
    localparam logic [7:0] IPSR_PRIO_GAP  = 8'h0f;  // slot with no register
    localparam logic [7:0] IPSR_IDX_TEST  = 8'h1d;
    localparam logic [7:0] IPSR_IDX_CPUST = 8'h1e;
    localparam logic [7:0] IPSR_IDX_CORE  = 8'h1f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int IPSR_NEST_OFF_BIT  = 15;
    localparam int IPSR_TRAP_LO       = 1;     // traps at bits 4:1
    localparam int IPSR_ALT_TABLE_BIT = 15;
    localparam int IPSR_LVL_LO        = 5;     // status bits 7:5
    localparam int IPSR_LVL_TOP_BIT   = 3;
    localparam int IPSR_TEST_LVL      = 8;     // test reg level at 11:8
    localparam int IPSR_PRIO_STEP     = 4;     // one field per nibble
    localparam logic [4:0][6:0] IPSR_EXT_VEC = {7'd54, 7'd53, 7'd29, 7'd20, 7'd0};

    // ------------------------------------------------------------
    // reset values and fixed levels
    // ------------------------------------------------------------
    localparam logic [2:0] IPSR_RST_LVL  = 3'h0;
    localparam logic [2:0] IPSR_LVL_MAX  = 3'h7;
    localparam logic [IPSR_NBITS-1:0] IPSR_IMPL_MASK = {{(IPSR_NBITS-IPSR_NSRC){1'b0}}, {IPSR_NSRC{1'b1}}};

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [IPSR_AW-1:0] addr;
        logic [IPSR_DW-1:0] wdata;
        logic               wr;
        logic               rd;
    } ipsr_bus_t;

    typedef struct packed {
        logic               req;
        logic [IPSR_VW-1:0] vector;
        logic [2:0]         level;
    } ipsr_cpu_req_t;

    typedef struct packed {
        logic                           nest_off;
        logic [3:0]                     trap;
        logic                           alt_table;
        logic [IPSR_NEXT-1:0]           ext_pol;
        logic [IPSR_NBITS-1:0]          flags;
        logic [IPSR_NBITS-1:0]          enables;
        logic [IPSR_NSRC-1:0][2:0]      prio;
        logic [2:0]                     lvl_lo;
        logic                           lvl_top;
        logic [IPSR_VW-1:0]             test_vec;
        logic [3:0]                     test_lvl;
        logic [IPSR_DW-1:0]             rdata;
        logic [IPSR_NEXT-1:0]           ext_s1;
        logic [IPSR_NEXT-1:0]           ext_s2;
        logic [IPSR_NEXT-1:0]           ext_prev;
    } ipsr_state_t;

endpackage

/* ipsr_arbiter.sv */
// picks the pending enabled source of highest priority, lowest vector on a tie
`timescale 1ns/1ns
module ipsr_arbiter #(
    parameter int N  = 68,
    parameter int VW = 7
) (
    input  wire logic [N-1:0]      pend,
    input  wire logic [N-1:0][2:0] prio,
    output logic                   win_valid,
    output logic [VW-1:0]          win_vec,
    output logic [2:0]             win_lvl
);

    logic [N-1:0][2:0] eff;

    // ------------------------------------------------------------
    // per-source gating
    // ------------------------------------------------------------
    // a source that is not pending competes at level 0, which never wins
    for (genvar g = 0; g < N; g++) begin : g_eff
        assign eff[g] = pend[g] ? prio[g] : 3'h0;
    end

    // ------------------------------------------------------------
    // search
    // ------------------------------------------------------------
    // walk downwards with >= so the lowest vector keeps a tie
    always_comb begin
        win_lvl = 3'h0;
        win_vec = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eff[i] != 3'h0 && eff[i] >= win_lvl) begin
                win_lvl = eff[i];
                win_vec = VW'(i);
            end
        end
        win_valid = (win_lvl != 3'h0);
    end

endmodule

/* ipsr_regs_chk.sv */
// assertion checker for the interrupt priority and status registers
`timescale 1ns/1ns
module ipsr_regs_chk
    import ipsr_pkg::*;
(
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire ipsr_pkg::ipsr_bus_t          bus,
    input wire logic [ipsr_pkg::IPSR_DW-1:0] bus_rdata,
    input wire logic                         trap_ack,
    input wire logic                         irq_ack,
    input wire logic                         level_restore,
    input wire ipsr_pkg::ipsr_cpu_req_t      cpu_req,
    input wire logic [3:0]                   cpu_level,
    input wire logic                         alt_vector_select,
    input wire logic                         nesting_disable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------
    // sequences: acceptance, and a status write no core event competes with
    // ------
    sequence s_accept;
        irq_ack && cpu_req.req;
    endsequence
    sequence s_st_wr;
        bus.wr && bus.addr == IPSR_IDX_CPUST && !irq_ack && !level_restore;
    endsequence
    property p_rd_idle;
        !bus.rd |=> bus_rdata == '0;
    endproperty
    property p_above;
        cpu_req.req |-> {1'b0, cpu_req.level} > cpu_level;
    endproperty
    property p_accept;
        s_accept ##0 !nesting_disable |=> cpu_level[2:0] == $past(cpu_req.level);
    endproperty
    property p_nest_acc;
        s_accept ##0 nesting_disable |=> cpu_level[2:0] == IPSR_LVL_MAX;
    endproperty
    property p_trap;
        trap_ack |=> cpu_level[3];
    endproperty
    // core write of a one must not raise the top bit; only a trap or a level restore may
    property p_top_ro;
        bus.wr && bus.addr == IPSR_IDX_CORE && !cpu_level[3] && !trap_ack && !level_restore |=> !cpu_level[3];
    endproperty
    property p_sw_lvl;
        s_st_wr ##0 !nesting_disable |=> cpu_level[2:0] == $past(bus.wdata[7:5]);
    endproperty
    property p_ro_lvl;
        s_st_wr ##0 nesting_disable |=> $stable(cpu_level[2:0]);
    endproperty
    property p_nest_bit;
        bus.wr && bus.addr == IPSR_IDX_CTL1 |=> nesting_disable == $past(bus.wdata[15]);
    endproperty
    property p_alt_bit;
        bus.wr && bus.addr == IPSR_IDX_CTL2 |=> alt_vector_select == $past(bus.wdata[15]);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_above: assert property (p_above) else $error("request not above level");
    a_accept: assert property (p_accept) else $error("level not taken on accept");
    a_nest_acc: assert property (p_nest_acc) else $error("no level 7 when unnested");
    a_trap: assert property (p_trap) else $error("top bit not set by trap");
    a_top_ro: assert property (p_top_ro) else $error("top bit set by software");
    a_sw_lvl: assert property (p_sw_lvl) else $error("status level not written");
    a_ro_lvl: assert property (p_ro_lvl) else $error("status level written");
    a_nest_bit: assert property (p_nest_bit) else $error("nesting bit wrong");
    a_alt_bit: assert property (p_alt_bit) else $error("alternate select wrong");
endmodule
bind ipsr_regs ipsr_regs_chk ipsr_regs_chk_i (.clk(clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
    .trap_ack(trap_ack), .irq_ack(irq_ack), .level_restore(level_restore), .cpu_req(cpu_req),
    .cpu_level(cpu_level), .alt_vector_select(alt_vector_select), .nesting_disable(nesting_disable));

/* ipsr_core_model.sv */
// behavioural cpu core that accepts presented interrupt requests
`timescale 1ns/1ns
module ipsr_core_model
    import ipsr_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire ipsr_pkg::ipsr_cpu_req_t cpu_req,
    input  wire logic                    enable,
    input  wire logic [3:0]              ack_wait,
    output logic                         irq_ack
);
    logic [3:0] wait_r;
    logic       ack_r;
    assign irq_ack = ack_r;
    // ack after ack_wait cycles of standing request; never two acks in a row,
    // so a request still high in the cycle after acceptance is not taken twice
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= '0;
            ack_r  <= 1'b0;
        end else if (enable && cpu_req.req && !ack_r && wait_r == ack_wait) begin
            wait_r <= '0;
            ack_r  <= 1'b1;
        end else begin
            wait_r <= (enable && cpu_req.req && !ack_r) ? wait_r + 4'h1 : 4'h0;
            ack_r  <= 1'b0;
        end
    end
endmodule

/* testbench.sv */
// self-checking testbench for the interrupt priority and status registers
`timescale 1ns/1ns
module testbench;
    import ipsr_pkg::*;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    ipsr_bus_t            bus = '0;
    logic [15:0]          bus_rdata;
    logic [IPSR_NSRC-1:0] src_req = '0;
    logic [4:0]           ext_irq = '0;
    logic [3:0]           trap_event = '0;
    logic                 trap_ack = 1'b0, level_restore = 1'b0, irq_ack, model_en = 1'b0;
    logic [3:0]           ack_wait = '0, cpu_level;
    ipsr_cpu_req_t        cpu_req;
    logic                 alt_sel, nest_dis;
    int                   num_errors = 0, comparisons = 0;
    logic [7:0]           regs [6] = '{8'h00, 8'h01, 8'h02, 8'h0c, 8'h1d, 8'h1f};

    ipsr_regs ipsr_regs_i (.clk(clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata), .src_req(src_req),
        .ext_irq(ext_irq), .trap_event(trap_event), .trap_ack(trap_ack), .irq_ack(irq_ack),
        .level_restore(level_restore), .level_restore_val(4'h0), .cpu_req(cpu_req), .cpu_level(cpu_level),
        .alt_vector_select(alt_sel), .nesting_disable(nest_dis));
    ipsr_core_model ipsr_core_model_i (.clk(clk), .rst_n(rst_n), .cpu_req(cpu_req), .enable(model_en),
        .ack_wait(ack_wait), .irq_ack(irq_ack));

    always #5 clk = ~clk;
    // ------
    // bus tasks and compare
    // ------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) bus <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge clk) bus <= '0;
        #1 chk(bus_rdata, e);
    endtask
    task automatic pulse_src(input int i);
        @(posedge clk) src_req[i] <= 1'b1;
        @(posedge clk) src_req <= '0;
    endtask
    task automatic restore0;
        @(posedge clk) level_restore <= 1'b1;
        @(posedge clk) level_restore <= 1'b0;
    endtask
    // bounded wait: the core model may answer slowly; start at a negedge so
    // a level update from the edge just passed is not missed
    task automatic wait_lvl(input logic [3:0] e);
        @(negedge clk);
        for (int n = 0; n < 30 && cpu_level !== e; n++) @(negedge clk);
        chk(cpu_level, e);
    endtask
    task automatic ext(input logic pol, input logic lvl, input logic [15:0] e);
        wr(8'h01, {15'h0, pol});
        wr(8'h02, 16'h0000);
        @(posedge clk) ext_irq[0] <= lvl;
        repeat (6) @(posedge clk);
        rd(8'h02, e);
    endtask
    task automatic close_out;
        $display("counts: %0d compared, %0d mismatched", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------
    // tests
    // ------
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) rd(regs[i], 16'h0000);
        wr(8'h1b, 16'hffff);
        rd(8'h1b, 16'h0000);
        wr(8'h00, 16'hffff);
        rd(8'h00, 16'h801e);
        chk(nest_dis, 16'h0001);
        wr(8'h1e, 16'hffff);
        rd(8'h1e, 16'h0000);
        wr(8'h01, 16'hffff);
        rd(8'h01, 16'h801f);
        chk(alt_sel, 16'h0001);
        wr(8'h06, 16'hffff);
        rd(8'h06, 16'h000f);
        wr(8'h0c, 16'hffff);
        rd(8'h0c, 16'h7777);
        wr(8'h00, 16'h0000);
        wr(8'h1e, 16'hffff);
        rd(8'h1e, 16'h00e0);
        wr(8'h1f, 16'hffff);
        rd(8'h1f, 16'h0000);
        chk(cpu_level, 16'h0007);
        wr(8'h1e, 16'h0000);
        $display("test done: register access");
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 16'h0000);
            @(posedge clk) trap_event <= 4'(1 << i);
            @(posedge clk) trap_event <= '0;
            rd(8'h00, 16'(2 << i));
        end
        wr(8'h00, 16'h0000);
        $display("test done: trap flags");
        wr(8'h0c, 16'h0550);
        pulse_src(1);
        pulse_src(2);
        rd(8'h02, 16'h0006);
        chk(cpu_req.req, 16'h0000);
        wr(8'h07, 16'h0006);
        #1 chk({cpu_req.req, cpu_req.vector, cpu_req.level}, 16'h040d);
        @(posedge clk) model_en <= 1'b1;
        wait_lvl(4'h5);
        rd(8'h1d, 16'h0501);
        chk(cpu_req.req, 16'h0000);
        wr(8'h02, 16'h0004);
        @(posedge clk) ack_wait <= 4'h5;
        restore0();
        wait_lvl(4'h5);
        rd(8'h1d, 16'h0502);
        wr(8'h00, 16'h8000);
        restore0();
        wait_lvl(4'h7);
        chk(cpu_req.req, 16'h0000);
        @(posedge clk) trap_ack <= 1'b1;
        @(posedge clk) trap_ack <= 1'b0;
        #1 chk(cpu_level, 16'h000f);
        rd(8'h1f, 16'h0008);
        wr(8'h1f, 16'h0000);
        rd(8'h1f, 16'h0000);
        @(posedge clk) model_en <= 1'b0;
        wr(8'h00, 16'h0000);
        wr(8'h07, 16'h0000);
        $display("test done: requests and levels");
        ext(1'b0, 1'b1, 16'h0001);
        ext(1'b0, 1'b0, 16'h0000);
        ext(1'b1, 1'b1, 16'h0000);
        ext(1'b1, 1'b0, 16'h0001);
        $display("test done: external pins");
        close_out();
    end
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        close_out();
    end
endmodule
